//--- common/fifo_flags_defs.svh
`ifndef FIFO_FLAGS_DEFS_SVH
`define FIFO_FLAGS_DEFS_SVH
// ****************************************
// register map
// ****************************************
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_LATENCY 8'h08
`define CTRL_DEPTH_LSB 0
`define CTRL_ECC_BIT 4
`define CTRL_NEWER_BIT 5
`define CTRL_SOFT_RST_BIT 8
`define CTRL_DEPTH_RESET 4'ha
`define CTRL_ECC_RESET 1'b0
`define CTRL_NEWER_RESET 1'b0
// ****************************************
// flag latencies in ticks of each clock
// ****************************************
`define FULL_RD 4'h1
`define FULL_FAST 4'h4
`define FULL_WR 4'h3
`define PFULL_RD 4'h1
`define PFULL_FAST 4'h3
`define PFULL_WR 4'h4
`define EMPTY_WR 4'h1
`define EMPTY_FAST 4'h5
`define EMPTY_RD 4'h4
`define PEMPTY_WR 4'h1
`define PEMPTY_FAST 4'h4
`define PEMPTY_RD 4'h4
// ****************************************
// cascade and reset figures
// ****************************************
`define ECC_PRIM_LOG2 4'h9
`define NEWER_MAX_LOG2 4'h4
`define RD_RST_TICKS 3'h4
`define PERIOD_MAX 8'hff
`define PROG_FULL_GAP 16'h0008
`define PROG_EMPTY_LEVEL 16'h0008
`endif

//--- common/fifo_flags_pkg.sv
package fifo_flags_pkg;
  typedef enum logic [2:0] {
    W_RUN = 3'b001,
    W_HOLD = 3'b010,
    W_WAIT = 3'b100
  } wr_rst_state_t;
  typedef enum logic [1:0] {
    R_RUN = 2'b01,
    R_BUSY = 2'b10
  } rd_rst_state_t;
endpackage

//--- logic/pin_sync.sv
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule // pin_sync
`default_nettype wire

//--- logic/flag_path.sv
`timescale 1ns/1ps
`default_nettype none
// three delay segments, each shifting on its own tick
module flag_path #(
  parameter int W = 11,
  parameter int MAXLEN = 15
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clear,
  input wire logic [2:0] tick,
  input wire logic [3:0] len_a,
  input wire logic [3:0] len_b,
  input wire logic [3:0] len_c,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] seg_in [0:3];
  logic [3:0] len [0:2];
  assign len[0] = len_a;
  assign len[1] = len_b;
  assign len[2] = len_c;
  assign seg_in[0] = din;
  assign dout = seg_in[3];
  genvar s;
  generate
    for (s = 0; s < 3; s++) begin : g_seg
      logic [W-1:0] stage [0:MAXLEN-1];
      // zero length passes straight through
      assign seg_in[s+1] = (len[s] == 4'h0) ? seg_in[s] :
                           stage[len[s] - 4'h1];
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          for (int i = 0; i < MAXLEN; i++) stage[i] <= '0;
        end else if (clear) begin
          for (int i = 0; i < MAXLEN; i++) stage[i] <= '0;
        end else if (tick[s]) begin
          stage[0] <= seg_in[s];
          for (int i = 1; i < MAXLEN; i++) stage[i] <= stage[i-1];
        end
      end
    end
  endgenerate
endmodule // flag_path
`default_nettype wire

//--- logic/fifo_flags_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
`include "fifo_flags_defs.svh"
// Function
// R1 - write: full/ack/overflow now, prog_full next
// R2 - read: empty/valid/underflow now, prog_empty next
// R3 - full clears 1 rd + (N-1)*4 fast + 3 wr; the code holds N at 4 for larger cascades
// R4 - prog_full 1 rd + (N-1)*3 fast + 4 wr; the code holds N at 4 for larger cascades
// R5 - empty clears 1 wr + (N-1)*5 fast + 4 rd; the code holds N at 4 for larger cascades
// R6 - prog_empty 1 wr + (N-1)*4 fast + 4 rd; the code holds N at 4 for larger cascades
// R7 - cascade is depth over primitive, ecc 512
// R8 - newer family, up to 16 primitives: N=1
// R9 - clock phase may add one cycle
// R10 - handshakes change only on own operations
// R11 - fast clock is the higher frequency one
// R12 - either reset clears counters and outputs
// R13 - async reset synchronised into each domain
// R14 - writer/reader keep enables still during reset
// R15 - both domain resets applied together
// R16 - no traffic until both domains reset
// R17 - sync reset on write clock raises write busy
// R18 - reset carried to read side, read busy
// R19 - clocks free running, gate with enables
// R20 - lost clock: hold flat, reset again
// R21 - full side pessimistic, almost one left
// R22 - empty side pessimistic, almost one word
module fifo_flags_ctrl #(
  parameter int AW = 10,
  parameter logic [3:0] PRIM_LOG2 = 4'ha
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic fifo_rst,
  input wire logic sync_rst,
  input wire logic wr_clk,
  input wire logic wr_en,
  input wire logic rd_clk,
  input wire logic rd_en,
  output logic full,
  output logic almost_full,
  output logic prog_full,
  output logic wr_ack,
  output logic overflow,
  output logic empty,
  output logic almost_empty,
  output logic prog_empty,
  output logic valid,
  output logic underflow,
  output logic wr_rst_busy,
  output logic rd_rst_busy
);
  import fifo_flags_pkg::*;
  localparam int CW = AW + 1;
  // ****************************************
  // pins and clock edges
  // ****************************************
  logic [5:0] pin_s;
  logic [5:0] pin_q;
  // R13 reset synchroniser
  pin_sync #(.W(6)) u_pin_sync (
    .clk(hclk),
    .rst_n(hresetn),
    .d({fifo_rst, sync_rst, wr_clk, wr_en, rd_clk, rd_en}),
    .q(pin_s)
  );
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) pin_q <= 6'h00;
    else pin_q <= pin_s;
  end
  wire rst_s = pin_s[5];
  // enables taken one cycle before the seen edge: the far side moves
  // them just after its own edge, so the older sample is the safe one
  wire sync_rst_q = pin_q[4];
  wire wr_en_q = pin_q[2];
  wire rd_en_q = pin_q[0];
  // R19 free-running clocks give ticks
  wire wr_tick = pin_s[3] & ~pin_q[3];
  wire rd_tick = pin_s[1] & ~pin_q[1];
  // ****************************************
  // faster clock detection
  // ****************************************
  logic [7:0] wr_per_cnt, rd_per_cnt, wr_period, rd_period;
  logic faster_is_rd;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_per_cnt <= 8'h00;
      rd_per_cnt <= 8'h00;
      wr_period <= `PERIOD_MAX;
      rd_period <= `PERIOD_MAX;
      faster_is_rd <= 1'b0;
    end else begin
      wr_per_cnt <= wr_tick ? 8'h00 :
        (wr_per_cnt == `PERIOD_MAX) ? wr_per_cnt : wr_per_cnt + 8'h01;
      rd_per_cnt <= rd_tick ? 8'h00 :
        (rd_per_cnt == `PERIOD_MAX) ? rd_per_cnt : rd_per_cnt + 8'h01;
      if (wr_tick) wr_period <= wr_per_cnt;
      if (rd_tick) rd_period <= rd_per_cnt;
      faster_is_rd <= rd_period < wr_period;
    end
  end
  // R11 fast tick follows the shorter period
  wire fast_tick = faster_is_rd ? rd_tick : wr_tick;
  // ****************************************
  // register bus
  // ****************************************
  logic a_wr;
  logic [7:0] a_addr;
  logic [3:0] depth_log2;
  logic ecc_en, newer_family, soft_rst;
  logic [31:0] rd_mux;
  wire ahb_take = hsel & hready & htrans[1];
  wire ctrl_wr = a_wr & (a_addr == `REG_CTRL);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      a_wr <= 1'b0;
      a_addr <= 8'h00;
      hrdata <= 32'h0;
      depth_log2 <= `CTRL_DEPTH_RESET;
      ecc_en <= `CTRL_ECC_RESET;
      newer_family <= `CTRL_NEWER_RESET;
      soft_rst <= 1'b0;
    end else begin
      a_wr <= ahb_take & hwrite;
      a_addr <= haddr[7:0];
      hrdata <= (ahb_take & ~hwrite) ? rd_mux : 32'h0;
      soft_rst <= ctrl_wr & hwdata[`CTRL_SOFT_RST_BIT];
      if (ctrl_wr) begin
        depth_log2 <= hwdata[`CTRL_DEPTH_LSB +: 4];
        ecc_en <= hwdata[`CTRL_ECC_BIT];
        newer_family <= hwdata[`CTRL_NEWER_BIT];
      end
    end
  end
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  // ****************************************
  // cascade count
  // ****************************************
  // R7 primitive depth, ecc uses 512 words
  wire [3:0] prim_log2 = ecc_en ? `ECC_PRIM_LOG2 : PRIM_LOG2;
  wire [3:0] depth_eff = (depth_log2 > 4'(AW)) ? 4'(AW) : depth_log2;
  wire [3:0] casc_log2 = (depth_eff > prim_log2) ?
                         depth_eff - prim_log2 : 4'h0;
  // R8 small cascades count as one
  wire newer_one = newer_family & (casc_log2 <= `NEWER_MAX_LOG2);
  // cascades beyond four are held at four to bound the delay lines
  wire [3:0] n_m1 = (newer_one | casc_log2 == 4'h0) ? 4'h0 :
                    (casc_log2 == 4'h1) ? 4'h1 : 4'h3;
  wire [3:0] f_fast = n_m1 * `FULL_FAST;
  wire [3:0] pf_fast = n_m1 * `PFULL_FAST;
  wire [3:0] e_fast = n_m1 * `EMPTY_FAST;
  wire [3:0] pe_fast = n_m1 * `PEMPTY_FAST;
  wire [CW-1:0] depth_words = {{AW{1'b0}}, 1'b1} << depth_eff;
  wire [CW-1:0] one_w = {{AW{1'b0}}, 1'b1};
  // ****************************************
  // reset sequencing
  // ****************************************
  wr_rst_state_t wr_state, next_wr_state;
  rd_rst_state_t rd_state, next_rd_state;
  logic rd_req_p1, rd_req_seen, wr_bsy_p1, wr_bsy_seen;
  logic [2:0] rd_rst_cnt;
  // R17 sync reset taken on a write edge
  wire wr_start = rst_s | soft_rst | (wr_tick & sync_rst_q);
  assign wr_rst_busy = (wr_state != W_RUN);
  assign rd_rst_busy = (rd_state == R_BUSY);
  wire to_rd = (wr_state == W_HOLD);
  always_comb begin
    next_wr_state = wr_state;
    case (wr_state)
      W_RUN: if (wr_start) next_wr_state = W_HOLD;
      W_HOLD: if (!rst_s && wr_bsy_seen) next_wr_state = W_WAIT;
      W_WAIT: begin
        if (wr_start) next_wr_state = W_HOLD;
        else if (!wr_bsy_seen) next_wr_state = W_RUN;
      end
      default: next_wr_state = W_HOLD;
    endcase
  end
  wire rd_hold = rst_s | (rd_tick & rd_req_seen);
  wire rd_last = rd_tick & (rd_rst_cnt == `RD_RST_TICKS - 3'h1);
  always_comb begin
    next_rd_state = rd_state;
    case (rd_state)
      R_RUN: if (rd_hold) next_rd_state = R_BUSY;
      R_BUSY: if (!rd_hold && !rd_req_seen && rd_last)
        next_rd_state = R_RUN;
      default: next_rd_state = R_BUSY;
    endcase
  end
  // R18 request crosses on read ticks, busy returns on write ticks
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_state <= W_HOLD;
      rd_state <= R_BUSY;
      rd_req_p1 <= 1'b1;
      rd_req_seen <= 1'b1;
      wr_bsy_p1 <= 1'b0;
      wr_bsy_seen <= 1'b0;
      rd_rst_cnt <= 3'h0;
    end else begin
      wr_state <= next_wr_state;
      rd_state <= next_rd_state;
      if (rd_tick) rd_req_p1 <= to_rd;
      if (rd_tick) rd_req_seen <= rd_req_p1;
      if (wr_tick) wr_bsy_p1 <= rd_rst_busy;
      if (wr_tick) wr_bsy_seen <= wr_bsy_p1;
      if (rd_hold || rd_state == R_RUN) rd_rst_cnt <= 3'h0;
      else if (rd_tick && !rd_last) rd_rst_cnt <= rd_rst_cnt + 3'h1;
    end
  end
  // R12 both resets clear state
  wire wr_clr = wr_start | wr_rst_busy;
  wire rd_clr = rst_s | rd_rst_busy;
  // ****************************************
  // crossing delay lines
  // ****************************************
  logic [CW-1:0] wptr, rptr, r_full_view, r_pf_view;
  logic [CW-1:0] w_empty_view, w_pe_view;
  wire path_clr = wr_clr | rd_clr;
  // R9 edge phase may cost one more tick
  // R3 full release path
  flag_path #(.W(CW)) u_full_path (
    .clk(hclk), .rst_n(hresetn), .clear(path_clr),
    .tick({wr_tick, fast_tick, rd_tick}),
    .len_a(`FULL_RD), .len_b(f_fast), .len_c(`FULL_WR - 4'h1),
    .din(rptr), .dout(r_full_view)
  );
  // R4 prog_full path
  flag_path #(.W(CW)) u_pfull_path (
    .clk(hclk), .rst_n(hresetn), .clear(path_clr),
    .tick({wr_tick, fast_tick, rd_tick}),
    .len_a(`PFULL_RD), .len_b(pf_fast), .len_c(`PFULL_WR - 4'h1),
    .din(rptr), .dout(r_pf_view)
  );
  // R5 empty release path
  flag_path #(.W(CW)) u_empty_path (
    .clk(hclk), .rst_n(hresetn), .clear(path_clr),
    .tick({rd_tick, fast_tick, wr_tick}),
    .len_a(`EMPTY_WR), .len_b(e_fast), .len_c(`EMPTY_RD - 4'h1),
    .din(wptr), .dout(w_empty_view)
  );
  // R6 prog_empty path
  flag_path #(.W(CW)) u_pempty_path (
    .clk(hclk), .rst_n(hresetn), .clear(path_clr),
    .tick({rd_tick, fast_tick, wr_tick}),
    .len_a(`PEMPTY_WR), .len_b(pe_fast), .len_c(`PEMPTY_RD - 4'h1),
    .din(wptr), .dout(w_pe_view)
  );
  // ****************************************
  // write side flags
  // ****************************************
  // R14 enables ignored while busy
  wire wr_do = wr_en_q & ~full;
  wire [CW-1:0] next_wptr = wptr + {{AW{1'b0}}, wr_do};
  // R21 counts only reads seen so far
  wire [CW-1:0] wcount_next = next_wptr - r_full_view;
  wire [CW-1:0] pf_count = wptr - r_pf_view;
  wire pf_next = 16'(pf_count) >= 16'(depth_words) - `PROG_FULL_GAP;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wptr <= '0;
      full <= 1'b0;
      almost_full <= 1'b0;
      prog_full <= 1'b0;
      wr_ack <= 1'b0;
      overflow <= 1'b0;
    end else if (wr_clr) begin
      wptr <= '0;
      full <= 1'b0;
      almost_full <= 1'b0;
      prog_full <= 1'b0;
      wr_ack <= 1'b0;
      overflow <= 1'b0;
    // R1 flags settle on the write edge
    // R10 handshakes move on write ticks
    end else if (wr_tick) begin
      wptr <= next_wptr;
      full <= wcount_next == depth_words;
      almost_full <= wcount_next == depth_words - one_w;
      prog_full <= pf_next;
      wr_ack <= wr_do;
      overflow <= wr_en_q & full;
    end
  end
  // ****************************************
  // read side flags, updated on read ticks while rd_clr is low
  // ****************************************
  // R16 no reads before both sides leave reset
  wire rd_do = rd_en_q & ~empty;
  wire [CW-1:0] next_rptr = rptr + {{AW{1'b0}}, rd_do};
  // R22 counts only writes seen so far
  wire [CW-1:0] rcount_next = w_empty_view - next_rptr;
  wire [CW-1:0] pe_count = w_pe_view - rptr;
  wire pe_next = 16'(pe_count) <= `PROG_EMPTY_LEVEL;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rptr <= '0;
      empty <= 1'b1;
      almost_empty <= 1'b0;
      prog_empty <= 1'b1;
      valid <= 1'b0;
      underflow <= 1'b0;
    end else if (rd_clr) begin
      rptr <= '0;
      empty <= 1'b1;
      almost_empty <= 1'b0;
      prog_empty <= 1'b1;
      valid <= 1'b0;
      underflow <= 1'b0;
    // R2 flags settle on the read edge
    // R10 handshakes move on read ticks
    end else if (rd_tick) begin
      rptr <= next_rptr;
      empty <= rcount_next == '0;
      almost_empty <= rcount_next == one_w;
      prog_empty <= pe_next;
      valid <= rd_do;
      underflow <= rd_en_q & empty;
    end
  end
  // ****************************************
  // read mux
  // ****************************************
  wire [CW-1:0] wcount_now = wptr - r_full_view;
  wire [15:0] status_lo = {7'h00, faster_is_rd, rd_rst_busy,
    wr_rst_busy, prog_empty, almost_empty, empty, prog_full,
    almost_full, full};
  wire [31:0] status_word = {16'(wcount_now), status_lo};
  wire [31:0] ctrl_word = {26'h0, newer_family, ecc_en, depth_log2};
  wire [31:0] lat_word = {12'h000, pe_fast, e_fast, pf_fast, f_fast,
                          n_m1 + 4'h1};
  assign rd_mux = (haddr[7:0] == `REG_CTRL) ? ctrl_word :
                  (haddr[7:0] == `REG_STATUS) ? status_word :
                  (haddr[7:0] == `REG_LATENCY) ? lat_word : 32'h0;
  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  chk_ack_on_write: assert property ( // R10
    $changed(wr_ack) |-> $past(wr_tick) || $past(wr_clr))
    else $error("wr_ack moved without a write edge");
  chk_valid_on_read: assert property ( // R10
    $changed(valid) |-> $past(rd_tick) || $past(rd_clr))
    else $error("valid moved without a read edge");
  chk_overflow_now: assert property ( // R1
    wr_tick && !wr_clr && wr_en_q && full |=> overflow && !wr_ack)
    else $error("overflow missing on write into full");
  chk_full_now: assert property ( // R1
    wr_tick && !wr_clr && wr_do && wcount_next == depth_words
    |=> full)
    else $error("full not set on last write");
  chk_underflow_now: assert property ( // R2
    rd_tick && !rd_clr && rd_en_q && empty |=> underflow && !valid)
    else $error("underflow missing on read of empty");
  chk_wbusy_srst: assert property ( // R17
    wr_tick && sync_rst_q |=> wr_rst_busy)
    else $error("write busy not raised by sync reset");
  chk_rbusy_nested: assert property ( // R18
    rd_rst_busy && !rst_s |-> wr_rst_busy || $past(wr_rst_busy))
    else $error("read busy outlived write busy");
  chk_busy_clears: assert property ( // R12
    wr_rst_busy |=> !full && !wr_ack && wptr == '0)
    else $error("write state not cleared in reset");
  chk_empty_in_rst: assert property ( // R12
    rd_rst_busy |=> empty && !valid)
    else $error("read state not cleared in reset");
  chk_af_exclusive: assert property ( // R21
    !(almost_full && full) && !(almost_empty && empty))
    else $error("almost and final flag both set");
  chk_newer_one: assert property ( // R8
    newer_family && casc_log2 <= `NEWER_MAX_LOG2 |-> f_fast == 4'h0)
    else $error("newer family cascade not one");
  cov_full_rise: cover property ($rose(full));
  cov_empty_fall: cover property ($fell(empty) && !rd_rst_busy);
  cov_overflow: cover property ($rose(overflow));
  cov_reset_seq: cover property ($fell(rd_rst_busy) ##[1:200]
                                 $fell(wr_rst_busy));
endmodule // fifo_flags_ctrl
`default_nettype wire

//--- sim/link_partner.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// writer and reader logic on the far side
// ****************************************
module link_partner #(
  parameter int WR_HALF = 200,
  parameter int RD_HALF = 260
) (
  input wire logic want_wr,
  input wire logic want_rd,
  input wire logic hold_wr,
  input wire logic wr_rst_busy,
  input wire logic rd_rst_busy,
  output logic wr_clk,
  output logic rd_clk,
  output logic wr_en,
  output logic rd_en
);
  // free running clocks, write side faster
  // hold_wr parks the write clock flat low, as a lost clock would
  initial begin
    wr_clk = 1'b0;
    #13;
    forever #(WR_HALF) wr_clk = ~wr_clk & ~hold_wr;
  end
  initial begin
    rd_clk = 1'b0;
    #37;
    forever #(RD_HALF) rd_clk = ~rd_clk;
  end
  // enables held low until both sides leave reset
  // one process per enable, so each has a single driver
  initial begin
    wr_en = 1'b0;
    forever begin
      @(negedge wr_clk);
      wr_en <= want_wr & ~wr_rst_busy & ~rd_rst_busy;
    end
  end
  initial begin
    rd_en = 1'b0;
    forever begin
      @(negedge rd_clk);
      rd_en <= want_rd & ~wr_rst_busy & ~rd_rst_busy;
    end
  end
endmodule // link_partner
`default_nettype wire

//--- sim/dual_clock_fifo_flags_reset_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module dual_clock_fifo_flags_reset_tb_top;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, got;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic fifo_rst, sync_rst, wr_clk, rd_clk, wr_en, rd_en, want_wr, want_rd;
  logic full, almost_full, prog_full, wr_ack, overflow;
  logic empty, almost_empty, prog_empty, valid, underflow;
  logic wr_rst_busy, rd_rst_busy, hold_wr;
  logic [31:0] ctrl_tab [3] = '{32'h0000010a, 32'h0000011a, 32'h0000013a};
  logic [31:0] lat_tab [3] = '{32'h00000001, 32'h00045342, 32'h00000001};
  int num_errors = 0;
  int checked = 0;
  int cycles = 0;
  int n;

  assign hready = hreadyout;

  fifo_flags_ctrl uut (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready, .hreadyout, .hresp, .hrdata, .fifo_rst, .sync_rst,
    .wr_clk, .wr_en, .rd_clk, .rd_en, .full, .almost_full, .prog_full,
    .wr_ack, .overflow, .empty, .almost_empty, .prog_empty, .valid,
    .underflow, .wr_rst_busy, .rd_rst_busy
  );

  link_partner partner (
    .want_wr, .want_rd, .hold_wr, .wr_rst_busy, .rd_rst_busy,
    .wr_clk, .rd_clk, .wr_en, .rd_en
  );

  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end

  // ****************************************
  // checking and closing
  // ****************************************
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] seen);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // the whole run needs a few thousand cycles
  always @(posedge hclk) begin
    cycles++;
    if (cycles == 40000) begin
      num_errors++;
      end_of_test;
    end
  end

  // ****************************************
  // bus and link tasks
  // ****************************************
  task automatic ahb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge hclk);
    haddr <= {24'h000000, a};
    hwrite <= w;
    htrans <= 2'b10;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    got = hrdata;
  endtask

  // soft reset shows up a few cycles after the bus write
  task automatic idle_wait;
    repeat (4) @(posedge hclk);
    n = 0;
    while ((wr_rst_busy !== 1'b0 || rd_rst_busy !== 1'b0) && n < 2000) begin
      @(posedge hclk);
      n++;
    end
    chk("reset_done", 32'h1, n < 2000);
  endtask

  // one write or read; outputs are looked at once the tick has landed
  task automatic tick(input logic w);
    @(posedge hclk);
    if (w) want_wr <= 1'b1;
    else want_rd <= 1'b1;
    if (w) @(negedge wr_clk);
    else @(negedge rd_clk);
    @(posedge hclk);
    want_wr <= 1'b0;
    want_rd <= 1'b0;
    if (w) @(posedge wr_clk);
    else @(posedge rd_clk);
    repeat (4) @(posedge hclk);
  endtask

  // ticks of the flag's own clock until full or empty falls
  task automatic lat(input logic w, input int lo);
    n = 0;
    while (((w ? full : empty) !== 1'b0) && n < 12) begin
      if (w) @(posedge wr_clk);
      else @(posedge rd_clk);
      repeat (4) @(posedge hclk);
      n++;
    end
    // leading cycle of the other clock plus phase slip adds up to three
    chk(w ? "full_fall" : "empty_fall", 32'h1, n >= lo && n <= lo + 3);
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    hresetn = 1'b0;
    hsel = 1'b1;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0;
    fifo_rst = 1'b0;
    sync_rst = 1'b0;
    want_wr = 1'b0;
    want_rd = 1'b0;
    hold_wr = 1'b0;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    ahb(1'b0, 8'h04, 32'h0);
    chk("busy_after_reset", 32'h3, (got >> 6) & 32'h3);
    idle_wait;
    ahb(1'b0, 8'h04, 32'h0);
    chk("status_reset", 32'h28, got);
    ahb(1'b0, 8'h00, 32'h0);
    chk("ctrl_reset", 32'h0a, got);
    chk("bus_okay", 32'h1, {hresp, hreadyout});
    ahb(1'b1, 8'h04, 32'hffffffff);
    ahb(1'b0, 8'h04, 32'h0);
    chk("status_ro", 32'h28, got);
    ahb(1'b1, 8'h0c, 32'h12345678);
    ahb(1'b0, 8'h0c, 32'h0);
    chk("unmapped", 32'h0, got);
    for (int i = 0; i < 3; i++) begin
      ahb(1'b1, 8'h00, ctrl_tab[i]);
      idle_wait;
      ahb(1'b0, 8'h08, 32'h0);
      chk("latency", lat_tab[i], got & 32'h000fffff);
    end
    $display("test registers done");

    // sixteen words keep the fill short
    ahb(1'b1, 8'h00, 32'h00000104);
    idle_wait;
    ahb(1'b0, 8'h00, 32'h0);
    chk("ctrl_depth", 32'h004, got);
    for (int k = 1; k <= 17; k++) begin
      tick(1'b1);
      chk("wr_ack", k <= 16, wr_ack);
      chk("overflow", k == 17, overflow);
      chk("almost_full", k == 15, almost_full);
      chk("full", k >= 16, full);
      chk("prog_full", k >= 9, prog_full);
      chk("read_side_quiet", 32'h0, valid | underflow);
      if (k == 1) lat(1'b0, 4);
    end
    $display("test fill done");

    for (int k = 1; k <= 17; k++) begin
      tick(1'b0);
      chk("valid", k <= 16, valid);
      chk("underflow", k == 17, underflow);
      chk("almost_empty", k == 15, almost_empty);
      chk("empty", k >= 16, empty);
      chk("prog_empty", k >= 9, prog_empty);
      chk("write_side_quiet", 32'h0, wr_ack);
      if (k == 1) lat(1'b1, 3);
    end
    $display("test drain done");

    tick(1'b1);
    tick(1'b1);
    @(posedge hclk);
    sync_rst <= 1'b1;
    @(posedge wr_clk);
    repeat (4) @(posedge hclk);
    chk("wr_busy", 32'h1, wr_rst_busy);
    sync_rst <= 1'b0;
    n = 0;
    while (rd_rst_busy !== 1'b1 && n < 400) begin
      @(posedge hclk);
      n++;
    end
    chk("rd_busy_follows", 32'h1, wr_rst_busy & rd_rst_busy);
    idle_wait;
    ahb(1'b0, 8'h04, 32'h0);
    chk("status_sync_rst", 32'h28, got);
    tick(1'b1);
    // write clock lost: parked flat, reset again once it runs
    @(posedge hclk);
    hold_wr <= 1'b1;
    repeat (40) @(posedge hclk);
    // no write edge while parked, so the acknowledge still stands
    chk("ack_while_parked", 32'h1, wr_ack);
    hold_wr <= 1'b0;
    repeat (20) @(posedge hclk);
    fifo_rst <= 1'b1;
    repeat (6) @(posedge hclk);
    chk("async_busy", 32'h3, {wr_rst_busy, rd_rst_busy});
    fifo_rst <= 1'b0;
    idle_wait;
    ahb(1'b0, 8'h04, 32'h0);
    chk("status_async_rst", 32'h28, got);
    $display("test resets done");
    end_of_test;
  end
endmodule // dual_clock_fifo_flags_reset_tb_top
`default_nettype wire
